// file: common/dis_regs.svh
// Notes on behaviour
// - stop-on-contact: a single select input picks its preset; second function alone: normal
// - no second function: high+middle speed 6, high+low 5, middle+low 4, all three 7
// - second function with low selects low preset; high, middle, high+middle as usual
// - remote setting function 1 to 3 disables stop-on-contact
// - exactly one start input runs the motor in its direction
// - both start inputs off or both on while running, stop selection time above 100: decelerate to stop
// - stop selection time 0 to 100: releasing start ends in coasting
// - ready output low during reset, high once reset is released
// - running output only while output frequency at or above starting frequency
// - supply, stop, braking, shutoff: ready high, running low; both high while operating
// - second function input swaps in the alternate parameter set
// - shutoff input while running cuts output at once, motor coasts
// - shutoff input active: start commands ignored
// - start released, shutoff inactive, stop selection time above 100: ramp down at deceleration rate; shutoff: coast
// - shutoff polarity 0 or 4 normally open, 2 normally closed
// - normally closed: open contact is the active shutoff condition
// - stop-on-contact low-speed frequency clamped to 30 Hz
// - stop selection time 0 to 100: output shuts off once that time has elapsed after start released
`ifndef DIS_REGS_SVH
`define DIS_REGS_SVH

`define DIS_ADDR_CTRL 8'h00
`define DIS_ADDR_START_FREQ 8'h04
`define DIS_ADDR_RATE0 8'h08
`define DIS_ADDR_PRESET0 8'h20
`define DIS_ADDR_STATUS 8'h40

`define DIS_CTRL_SOC_BIT 0
`define DIS_CTRL_RSF_LSB 1
`define DIS_CTRL_POL_LSB 4
`define DIS_CTRL_SST_LSB 16

`define DIS_SST_RESET 16'h270F
`define DIS_SST_COAST_MAX 16'h0064
`define DIS_POL_NC 4'h2
`define DIS_FSTART_RESET 16'h0005
`define DIS_RATE_RESET 32'h0000_1000
`define DIS_PRESET_HIGH_RESET 16'h0258
`define DIS_PRESET_MID_RESET 16'h012C
`define DIS_PRESET_LOW_RESET 16'h0064
`define DIS_SOC_MAX_FREQ 16'h012C

`define DIS_CLK_PERIOD_NS 10
`define DIS_SECOND_NS 1000000000

`define DIS_PIN_HIGH 0
`define DIS_PIN_MID 1
`define DIS_PIN_LOW 2
`define DIS_PIN_SECOND 3
`define DIS_PIN_FWD 4
`define DIS_PIN_REV 5
`define DIS_PIN_SHUTOFF 6
`define DIS_PIN_AUX 7
`define DIS_PIN_FAULT 8
`define DIS_PIN_SAFETY 9
`define DIS_PIN_DCBRAKE 10
`define DIS_PIN_COUNT 11

`endif

// file: common/dis_pkg.sv
package dis_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_DELAY} dis_state_t;

  // index order matches the preset register order
  typedef enum logic [2:0] {
    FS_NORMAL, FS_HIGH, FS_MID, FS_LOW, FS_SPEED4, FS_SPEED5, FS_SPEED6, FS_SPEED7
  } dis_freq_src_t;

endpackage : dis_pkg

// file: common/dis_sync_if.sv
`timescale 1ns/100ps
interface dis_sync_if #(parameter int W = 11);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : dis_sync_if

// file: design/dis_input_sync.sv
`timescale 1ns/100ps
module dis_input_sync #(
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  dis_sync_if.sync pins
);
  import dis_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } dis_sync_state_t;

  dis_sync_state_t s_reg;
  dis_sync_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // a bit changes only once stages two and three agree, filtering one-cycle glitches
  always_comb
  begin
    s_next = s_reg;
    if (ce)
    begin
      s_next.s1 = pins.raw;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      for (int i = 0; i < W; i++)
      begin
        if (s_reg.s2[i] == s_reg.s3[i])
        begin
          s_next.clean[i] = s_reg.s3[i];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign pins.clean = s_reg.clean;

endmodule : dis_input_sync

// file: design/dis_drive_top.sv
`timescale 1ns/100ps
`include "dis_regs.svh"
module dis_drive_top #(
  parameter int unsigned SEC_CYCLES = `DIS_SECOND_NS / `DIS_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic high_speed_select,
  input wire logic middle_speed_select,
  input wire logic low_speed_select,
  input wire logic second_function_select,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic output_shutoff_input,
  input wire logic aux_supply_active,
  input wire logic fault_input,
  input wire logic safety_stop_input,
  input wire logic dc_brake_input,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ready_status,
  output logic running_status,
  output logic output_enable,
  output logic rotate_reverse,
  output logic second_param_set,
  output logic stop_on_contact_active,
  output logic [15:0] output_frequency
);
  import dis_pkg::*;

  typedef struct packed {
    dis_state_t st;
    logic [7:0][15:0] preset;
    logic soc_en;
    logic [2:0] rsf;
    logic [3:0] pol;
    logic [15:0] sst;
    logic [15:0] fstart;
    logic [3:0][31:0] rate;
    logic [31:0] step_cnt;
    logic [31:0] sec_cnt;
    logic [15:0] sec_left;
    logic [15:0] freq;
    logic out_en;
    logic reverse;
    logic ready;
    logic running;
    logic second;
    logic soc_act;
    logic shut_act;
    dis_freq_src_t src;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dis_top_state_t;

  dis_top_state_t s_reg;
  dis_top_state_t s_next;
  dis_sync_if #(.W(`DIS_PIN_COUNT)) pins ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  assign pins.raw = {dc_brake_input, safety_stop_input, fault_input, aux_supply_active,
                     output_shutoff_input, reverse_start_input, forward_start_input,
                     second_function_select, low_speed_select, middle_speed_select,
                     high_speed_select};

  dis_input_sync #(.W(`DIS_PIN_COUNT)) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic dis_freq_src_t decode_src(logic h, logic m, logic l, logic rt);
    dis_freq_src_t r;
    r = FS_NORMAL;
    if (l && rt)
    begin
      r = FS_LOW;
    end
    else if (h && m && l)
    begin
      r = FS_SPEED7;
    end
    else if (h && m)
    begin
      r = FS_SPEED6;
    end
    else if (h && l)
    begin
      r = FS_SPEED5;
    end
    else if (m && l)
    begin
      r = FS_SPEED4;
    end
    else if (h)
    begin
      r = FS_HIGH;
    end
    else if (m)
    begin
      r = FS_MID;
    end
    else if (l)
    begin
      r = FS_LOW;
    end
    return r;
  endfunction : decode_src

  function automatic logic [31:0] reg_image(dis_top_state_t s, logic [7:0] a, output logic hit);
    logic [31:0] r;
    r = 32'h0000_0000;
    hit = 1'b1;
    if (a == `DIS_ADDR_CTRL)
    begin
      r[`DIS_CTRL_SOC_BIT] = s.soc_en;
      r[`DIS_CTRL_RSF_LSB +: 3] = s.rsf;
      r[`DIS_CTRL_POL_LSB +: 4] = s.pol;
      r[`DIS_CTRL_SST_LSB +: 16] = s.sst;
    end
    else if (a == `DIS_ADDR_START_FREQ)
    begin
      r[15:0] = s.fstart;
    end
    else if (a >= `DIS_ADDR_RATE0 && a < `DIS_ADDR_RATE0 + 8'h10 && a[1:0] == 2'h0)
    begin
      r = s.rate[a[3:2] - 2'h2];
    end
    else if (a >= `DIS_ADDR_PRESET0 && a < `DIS_ADDR_STATUS && a[1:0] == 2'h0)
    begin
      r[15:0] = s.preset[a[4:2]];
    end
    else if (a == `DIS_ADDR_STATUS)
    begin
      r = {s.freq, 2'h0, s.st, 1'b0, s.src, 1'b0, s.shut_act, s.soc_act, s.second,
           s.reverse, s.out_en, s.running, s.ready};
    end
    else
    begin
      hit = 1'b0;
    end
    return r;
  endfunction : reg_image

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [`DIS_PIN_COUNT-1:0] p;
    logic fwd;
    logic rev;
    logic start;
    logic shut_any;
    logic soc_ok;
    logic hit;
    logic up;
    logic [15:0] tgt;
    logic [31:0] img;
    logic [31:0] wv;
    p = pins.clean;
    fwd = 1'b0;
    rev = 1'b0;
    start = 1'b0;
    shut_any = 1'b0;
    soc_ok = 1'b0;
    hit = 1'b0;
    up = 1'b0;
    tgt = 16'h0000;
    img = 32'h0000_0000;
    wv = 32'h0000_0000;
    s_next = s_reg;
    if (ce)
    begin
      s_next.ready = 1'b1;
      // closed contact reads high; normally closed logic makes an open contact active
      s_next.shut_act = (s_reg.pol == `DIS_POL_NC) ? !p[`DIS_PIN_SHUTOFF]
                                                   : p[`DIS_PIN_SHUTOFF];
      shut_any = s_reg.shut_act || p[`DIS_PIN_FAULT] || p[`DIS_PIN_SAFETY]
                 || p[`DIS_PIN_AUX];
      fwd = p[`DIS_PIN_FWD] && !p[`DIS_PIN_REV];
      rev = p[`DIS_PIN_REV] && !p[`DIS_PIN_FWD];
      start = fwd || rev;
      s_next.second = p[`DIS_PIN_SECOND];
      s_next.src = decode_src(p[`DIS_PIN_HIGH], p[`DIS_PIN_MID], p[`DIS_PIN_LOW],
                              p[`DIS_PIN_SECOND]);
      soc_ok = s_reg.soc_en && !(s_reg.rsf >= 3'h1 && s_reg.rsf <= 3'h3);
      s_next.soc_act = soc_ok && p[`DIS_PIN_LOW] && p[`DIS_PIN_SECOND];
      tgt = s_reg.preset[s_reg.src];
      if (s_reg.soc_act && tgt > `DIS_SOC_MAX_FREQ)
      begin
        tgt = `DIS_SOC_MAX_FREQ;
      end
      // a reversal request ramps to zero before the direction flips
      if (s_reg.st == ST_RUN && start && rev != s_reg.reverse)
      begin
        tgt = 16'h0000;
        if (s_reg.freq == 16'h0000)
        begin
          s_next.reverse = rev;
        end
      end
      if (s_reg.st == ST_DECEL)
      begin
        tgt = 16'h0000;
      end
      up = s_reg.freq < tgt;
      if (s_reg.freq != tgt)
      begin
        // second set picks the alternate acceleration and deceleration rates
        if (s_reg.step_cnt >= s_reg.rate[{s_reg.second, !up}])
        begin
          s_next.step_cnt = 32'h0000_0000;
          s_next.freq = up ? s_reg.freq + 16'h0001 : s_reg.freq - 16'h0001;
        end
        else
        begin
          s_next.step_cnt = s_reg.step_cnt + 32'h0000_0001;
        end
      end
      else
      begin
        s_next.step_cnt = 32'h0000_0000;
      end
      if (s_reg.sec_cnt >= SEC_CYCLES - 1)
      begin
        s_next.sec_cnt = 32'h0000_0000;
        if (s_reg.sec_left != 16'h0000)
        begin
          s_next.sec_left = s_reg.sec_left - 16'h0001;
        end
      end
      else
      begin
        s_next.sec_cnt = s_reg.sec_cnt + 32'h0000_0001;
      end
      case (s_reg.st)
        ST_IDLE:
        begin
          s_next.freq = 16'h0000;
          s_next.out_en = 1'b0;
          if (start && !shut_any)
          begin
            s_next.st = ST_RUN;
            s_next.reverse = rev;
            s_next.out_en = 1'b1;
            s_next.freq = s_reg.fstart;
          end
        end
        ST_RUN, ST_DECEL, ST_DELAY:
        begin
          if (shut_any)
          begin
            s_next.st = ST_IDLE;
            s_next.out_en = 1'b0;
            s_next.freq = 16'h0000;
          end
          else if (start && s_reg.st != ST_RUN)
          begin
            s_next.st = ST_RUN;
          end
          else if (!start && s_reg.st == ST_RUN)
          begin
            if (s_reg.sst <= `DIS_SST_COAST_MAX)
            begin
              s_next.st = ST_DELAY;
              s_next.sec_cnt = 32'h0000_0000;
              s_next.sec_left = s_reg.sst;
            end
            else
            begin
              s_next.st = ST_DECEL;
            end
          end
          else if ((s_reg.st == ST_DELAY && s_reg.sec_left == 16'h0000)
                   || (s_reg.st == ST_DECEL && s_reg.freq == 16'h0000))
          begin
            s_next.st = ST_IDLE;
            s_next.out_en = 1'b0;
            s_next.freq = 16'h0000;
          end
        end
        default:
        begin
          s_next.st = ST_IDLE;
        end
      endcase
      s_next.running = s_next.out_en && s_next.freq >= s_reg.fstart
                       && !p[`DIS_PIN_DCBRAKE];
      ////////////////////////////////////////////////////////////////////////
      // write channel: address and data accepted in either order
      if (s_reg.awready && s_axi_awvalid)
      begin
        s_next.aw_got = 1'b1;
        s_next.awaddr = s_axi_awaddr;
        s_next.awready = 1'b0;
      end
      if (s_reg.wready && s_axi_wvalid)
      begin
        s_next.w_got = 1'b1;
        s_next.wdata = s_axi_wdata;
        s_next.wstrb = s_axi_wstrb;
        s_next.wready = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
      begin
        img = reg_image(s_reg, s_reg.awaddr, hit);
        wv = merge(img, s_reg.wdata, s_reg.wstrb);
        s_next.bvalid = 1'b1;
        s_next.bresp = hit ? 2'h0 : 2'h2;
        s_next.aw_got = 1'b0;
        s_next.w_got = 1'b0;
        if (s_reg.awaddr == `DIS_ADDR_CTRL)
        begin
          s_next.soc_en = wv[`DIS_CTRL_SOC_BIT];
          s_next.rsf = wv[`DIS_CTRL_RSF_LSB +: 3];
          s_next.pol = wv[`DIS_CTRL_POL_LSB +: 4];
          s_next.sst = wv[`DIS_CTRL_SST_LSB +: 16];
        end
        else if (s_reg.awaddr == `DIS_ADDR_START_FREQ)
        begin
          s_next.fstart = wv[15:0];
        end
        else if (hit && s_reg.awaddr >= `DIS_ADDR_RATE0 && s_reg.awaddr < `DIS_ADDR_PRESET0)
        begin
          s_next.rate[s_reg.awaddr[3:2] - 2'h2] = wv;
        end
        else if (hit && s_reg.awaddr >= `DIS_ADDR_PRESET0 && s_reg.awaddr < `DIS_ADDR_STATUS)
        begin
          s_next.preset[s_reg.awaddr[4:2]] = wv[15:0];
        end
      end
      if (s_reg.bvalid && s_axi_bready)
      begin
        s_next.bvalid = 1'b0;
        s_next.awready = 1'b1;
        s_next.wready = 1'b1;
      end
      ////////////////////////////////////////////////////////////////////////
      // read channel
      if (s_reg.arready && s_axi_arvalid)
      begin
        s_next.rdata = reg_image(s_reg, s_axi_araddr, hit);
        s_next.rresp = hit ? 2'h0 : 2'h2;
        s_next.rvalid = 1'b1;
        s_next.arready = 1'b0;
      end
      if (s_reg.rvalid && s_axi_rready)
      begin
        s_next.rvalid = 1'b0;
        s_next.arready = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
      s_reg.sst <= `DIS_SST_RESET;
      s_reg.fstart <= `DIS_FSTART_RESET;
      s_reg.rate <= {4{`DIS_RATE_RESET}};
      s_reg.preset[FS_HIGH] <= `DIS_PRESET_HIGH_RESET;
      s_reg.preset[FS_MID] <= `DIS_PRESET_MID_RESET;
      s_reg.preset[FS_LOW] <= `DIS_PRESET_LOW_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign ready_status = s_reg.ready;
  assign running_status = s_reg.running;
  assign output_enable = s_reg.out_en;
  assign rotate_reverse = s_reg.reverse;
  assign second_param_set = s_reg.second;
  assign stop_on_contact_active = s_reg.soc_act;
  assign output_frequency = s_reg.freq;

endmodule : dis_drive_top

// file: testbench/dis_drive_assertions.sv
`timescale 1ns/100ps
module dis_drive_assertions #(
  parameter int unsigned SEC_CYCLES = 10
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic second_function_select,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic aux_supply_active,
  input wire logic fault_input,
  input wire logic safety_stop_input,
  input wire logic dc_brake_input,
  input wire logic ready_status,
  input wire logic running_status,
  input wire logic output_enable,
  input wire logic second_param_set,
  input wire logic [15:0] output_frequency
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // pins take four edges through the synchroniser and one more into state, so hold seven
  chk_ready_low: assert property (disable iff (1'b0) srst |=> !ready_status)
    else $error("ready high during reset");
  chk_ready_high: assert property (ce |=> ready_status)
    else $error("ready low after reset");
  chk_run_freq: assert property (running_status |-> output_enable
    && output_frequency >= 16'h0005)
    else $error("running below start frequency");
  chk_brake_run: assert property ((dc_brake_input && ce) [*7] |-> !running_status)
    else $error("running during braking");
  chk_fault_off: assert property ((fault_input && ce) [*7]
    |-> !output_enable && !running_status && ready_status)
    else $error("output on during fault");
  chk_safety_off: assert property ((safety_stop_input && ce) [*7]
    |-> !output_enable && !running_status && ready_status)
    else $error("output on during safety stop");
  chk_aux_off: assert property ((aux_supply_active && ce) [*7]
    |-> !output_enable && !running_status && ready_status)
    else $error("output on under aux supply");
  chk_second_on: assert property ((second_function_select && ce) [*7]
    |-> second_param_set)
    else $error("second set not selected");
  chk_second_off: assert property ((!second_function_select && ce) [*7]
    |-> !second_param_set)
    else $error("second set stuck");
  chk_no_start: assert property ((!forward_start_input && !reverse_start_input && ce) [*7]
    ##0 !output_enable |=> !output_enable)
    else $error("output on without start");
endmodule : dis_drive_assertions
bind dis_drive_top dis_drive_assertions #(.SEC_CYCLES(SEC_CYCLES)) chk_u (
  .clk(clk), .srst(srst), .ce(ce),
  .second_function_select(second_function_select),
  .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input),
  .aux_supply_active(aux_supply_active), .fault_input(fault_input),
  .safety_stop_input(safety_stop_input), .dc_brake_input(dc_brake_input),
  .ready_status(ready_status), .running_status(running_status),
  .output_enable(output_enable), .second_param_set(second_param_set),
  .output_frequency(output_frequency)
);

// file: testbench/dis_host_model.sv
`timescale 1ns/100ps
module dis_host_model (
  input wire logic clk,
  input wire logic [10:0] want,
  output logic [10:0] pins
);
  // contacts move only on a clock edge; start pins as commanded
  always @(posedge clk)
    pins <= want;
endmodule : dis_host_model

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`include "dis_regs.svh"
module tb_top;
  logic clk = 0, srst = 1, ce = 1;
  logic [10:0] want = '0;
  logic [10:0] pins;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rd;
  logic [1:0] resp, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, ready_st, run_st, out_en, rev, sec_set, soc;
  logic [31:0] rdata;
  logic [15:0] freq, held;
  int miscompares = 0, checks = 0, cycles = 0;
  logic [2:0] src_tab [16] = '{0, 1, 2, 6, 3, 5, 4, 7, 0, 1, 2, 6, 3, 3, 3, 3};
  localparam logic [10:0] H = 11'h001, L = 11'h004, S = 11'h008, F = 11'h010, R = 11'h020;
  localparam logic [10:0] OFF = 11'h040;
  dis_host_model host_u (.clk(clk), .want(want), .pins(pins));
  dis_drive_top #(.SEC_CYCLES(10)) dut_u (
    .clk(clk), .srst(srst), .ce(ce),
    .high_speed_select(pins[`DIS_PIN_HIGH]), .middle_speed_select(pins[`DIS_PIN_MID]),
    .low_speed_select(pins[`DIS_PIN_LOW]), .second_function_select(pins[`DIS_PIN_SECOND]),
    .forward_start_input(pins[`DIS_PIN_FWD]), .reverse_start_input(pins[`DIS_PIN_REV]),
    .output_shutoff_input(pins[`DIS_PIN_SHUTOFF]), .aux_supply_active(pins[`DIS_PIN_AUX]),
    .fault_input(pins[`DIS_PIN_FAULT]), .safety_stop_input(pins[`DIS_PIN_SAFETY]),
    .dc_brake_input(pins[`DIS_PIN_DCBRAKE]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ready_status(ready_st), .running_status(run_st), .output_enable(out_en),
    .rotate_reverse(rev), .second_param_set(sec_set), .stop_on_contact_active(soc),
    .output_frequency(freq)
  );
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // checks sample at the edge, before the design's own updates land
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask : wr
  task rdr(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask : rdr
  // eight edges cover the synchroniser and one state update
  task pins_set(input logic [10:0] v);
    @(posedge clk);
    want <= v;
    repeat (8) @(posedge clk);
  endtask : pins_set
  task wait_en(input logic v);
    for (int n = 0; n < 700 && out_en !== v; n++)
      @(posedge clk);
    check(out_en, v);
  endtask : wait_en
  task run_up;
    pins_set(H | F);
    for (int n = 0; n < 300 && freq !== 16'h0032; n++)
      @(posedge clk);
    check(freq, 16'h0032);
  endtask : run_up
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    check(ready_st, 1'b1);
    check(run_st, 1'b0);
    rdr(`DIS_ADDR_CTRL);
    check(rd, 32'h270F_0000);
    rdr(`DIS_ADDR_START_FREQ);
    check(rd, 32'h0000_0005);
    rdr(8'h44);
    check(rd, 32'h0);
    check(resp, 2'h2);
    wr(8'h44, 32'h0);
    check(resp, 2'h2);
  endtask : t_reset
  task t_decode;
    for (int i = 0; i < 16; i++)
    begin
      pins_set(11'(i));
      rdr(`DIS_ADDR_STATUS);
      check(rd[10:8], src_tab[i]);
      check(sec_set, i[3]);
    end
  endtask : t_decode
  task t_run;
    for (int i = 0; i < 4; i++)
      wr(`DIS_ADDR_RATE0 + 8'(4 * i), 32'h0);
    wr(`DIS_ADDR_PRESET0 + 8'h04, 32'h0000_0032);
    check(resp, 2'h0);
    run_up();
    check({out_en, run_st, rev}, 3'b110);
    pins_set(H | F | R);
    wait_en(1'b0);
    check(run_st, 1'b0);
    pins_set(H | R);
    check({out_en, rev}, 2'b11);
    // a reversal while running ramps through zero, then flips direction
    pins_set(H | F);
    repeat (40) @(posedge clk);
    check({out_en, rev}, 2'b10);
    pins_set(H);
    wait_en(1'b0);
    check(freq, 16'h0);
  endtask : t_run
  task t_coast;
    wr(`DIS_ADDR_CTRL, 32'h0002_0000);
    run_up();
    pins_set(H);
    check(out_en, 1'b1);
    repeat (30) @(posedge clk);
    check({out_en, run_st}, 2'b00);
    wr(`DIS_ADDR_CTRL, 32'h270F_0000);
  endtask : t_coast
  task t_shutoff;
    for (int p = 0; p < 5; p += 4)
    begin
      wr(`DIS_ADDR_CTRL, {16'h270F, 8'h0, 4'(p), 4'h0});
      run_up();
      // a ramp would still be running here, so off means a coast
      pins_set(H | F | OFF);
      check({out_en, run_st, ready_st}, 3'b001);
      repeat (10) @(posedge clk);
      check(out_en, 1'b0);
      pins_set(11'h0);
    end
    wr(`DIS_ADDR_CTRL, {16'h270F, 8'h0, `DIS_POL_NC, 4'h0});
    pins_set(H | F);
    check(out_en, 1'b0);
    pins_set(H | F | OFF);
    check(out_en, 1'b1);
    pins_set(OFF);
    wait_en(1'b0);
    wr(`DIS_ADDR_CTRL, 32'h270F_0000);
  endtask : t_shutoff
  task t_forced;
    for (int k = `DIS_PIN_AUX; k <= `DIS_PIN_DCBRAKE; k++)
    begin
      pins_set(H | F);
      wait_en(1'b1);
      pins_set(H | F | (11'h1 << k));
      check({run_st, ready_st}, 2'b01);
      check(out_en, k == `DIS_PIN_DCBRAKE);
      pins_set(11'h0);
      wait_en(1'b0);
    end
  endtask : t_forced
  task t_soc;
    wr(`DIS_ADDR_PRESET0 + 8'h0C, 32'h0000_0190);
    wr(`DIS_ADDR_CTRL, 32'h270F_0001);
    pins_set(L | S | F);
    // clock enable low must freeze the ramp in mid-flight
    repeat (100) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    held = freq;
    repeat (20) @(posedge clk);
    check(freq, held);
    ce <= 1'b1;
    repeat (500) @(posedge clk);
    check(freq, 16'h012C);
    check(soc, 1'b1);
    for (int r = 1; r < 5; r++)
    begin
      wr(`DIS_ADDR_CTRL, {16'h270F, 12'h0, 3'(r), 1'b1});
      repeat (4) @(posedge clk);
      check(soc, r == 4);
    end
    pins_set(11'h0);
    wait_en(1'b0);
  endtask : t_soc
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_decode();
    t_run();
    t_coast();
    t_shutoff();
    t_forced();
    t_soc();
    end_of_test();
  end
endmodule : tb_top
